// File: include/slr_pkg.sv
// package for the serial-to-parallel latch register
// shared widths, reset values and the pin carrier struct
package slr_pkg;
	localparam int          SLR_WIDTH     = 8;
	localparam logic [7:0]  SLR_RESET_VAL = 8'h00;
	localparam int          SLR_SYNC_LEN  = 2;

	// pins driven by the host, before and after synchronisation
	typedef struct packed {
		logic bit_stream_in;
		logic shift_clock_in;
		logic store_clock_in;
		logic shift_clear_n;
		logic out_enable_n;
	} slr_pins_t;
endpackage : slr_pkg

// File: src/slr_top.sv
// serial-in, parallel-out shift register with a three-state storage register
// assumes host pins are asynchronous to clk_sys and pulse wider than one clk_sys period
`timescale 1ns/1ps
`default_nettype none
module slr_top
	import slr_pkg::*;
#(
	parameter int WIDTH = SLR_WIDTH
)(
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             bit_stream_in,
	input  wire logic             shift_clock_in,
	input  wire logic             store_clock_in,
	input  wire logic             shift_clear_n,
	input  wire logic             out_enable_n,
	output logic      [WIDTH-1:0] par_out,
	output logic      [WIDTH-1:0] par_out_oe,
	output logic                  cascade_out
);
	// host pins gathered into one carrier before synchronisation
	slr_pins_t             pins_raw;
	slr_pins_t             meta_q;
	slr_pins_t             meta_d;
	slr_pins_t             sync_q;
	slr_pins_t             sync_d;
	slr_pins_t             last_q;
	slr_pins_t             last_d;
	// shift stages, storage register and the pulses that move them
	logic      [WIDTH-1:0] shift_q;
	logic      [WIDTH-1:0] shift_d;
	logic      [WIDTH-1:0] store_q;
	logic      [WIDTH-1:0] store_d;
	wire logic [WIDTH-1:0] stage_in;
	logic                  shift_rise;
	logic                  store_rise;
	logic                  clear_act;
	logic                  serial_bit;
	logic                  drive_en;

	// rising edge of one synchronised pin against its delayed copy
	function automatic logic slr_rise(
		input logic now_lvl,
		input logic old_lvl
	);
		return now_lvl & ~old_lvl;
	endfunction : slr_rise

	// levels held in reset: clocks low, clear and enable inactive
	function automatic slr_pins_t slr_idle_pins();
		slr_pins_t idle;
		idle.bit_stream_in  = 1'b0;
		idle.shift_clock_in = 1'b0;
		idle.store_clock_in = 1'b0;
		idle.shift_clear_n  = 1'b1;
		idle.out_enable_n   = 1'b1;
		return idle;
	endfunction : slr_idle_pins

	always_comb begin
		pins_raw.bit_stream_in  = bit_stream_in;
		pins_raw.shift_clock_in = shift_clock_in;
		pins_raw.store_clock_in = store_clock_in;
		pins_raw.shift_clear_n  = shift_clear_n;
		pins_raw.out_enable_n   = out_enable_n;
	end

	// two flip-flops per pin; the third copy only feeds the edge detectors
	always_comb begin
		meta_d = pins_raw;
		sync_d = meta_q;
		last_d = sync_q;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q <= slr_idle_pins();
			sync_q <= slr_idle_pins();
			last_q <= slr_idle_pins();
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	// only rising edges of the two clocks act; the clear acts on its level, falling clock edges change nothing
	// a pin pulse shorter than one clk_sys period may be lost in the synchroniser
	assign shift_rise = slr_rise(sync_q.shift_clock_in, last_q.shift_clock_in);
	assign store_rise = slr_rise(sync_q.store_clock_in, last_q.store_clock_in);
	assign clear_act  = ~sync_q.shift_clear_n;
	assign serial_bit = sync_q.bit_stream_in;

	// stage 0 takes the serial bit, each later stage its lower neighbour
	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_stage
			if (i == 0) begin : g_first
				assign stage_in[i] = serial_bit;
			end else begin : g_next
				assign stage_in[i] = shift_q[i-1];
			end
		end
	endgenerate

	// clear overrides any shift edge in the same cycle
	// it acts on the synchronised level, so it lands three cycles after the pin
	always_comb begin
		shift_d = shift_q;
		if (clear_act) begin
			shift_d = '0;
		end else if (shift_rise) begin
			shift_d = stage_in;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			shift_q <= WIDTH'(SLR_RESET_VAL);
		end else begin
			shift_q <= shift_d;
		end
	end

	// storage copies the stages as they stood before this cycle's shift
	// so tied clocks leave storage one pulse behind; the clear never reaches it
	always_comb begin
		store_d = store_q;
		if (store_rise) begin
			store_d = shift_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			store_q <= WIDTH'(SLR_RESET_VAL);
		end else begin
			store_q <= store_d;
		end
	end

	// bit 0 is the first stage and the first output
	// the enable covers only the parallel outputs, never the cascade
	assign drive_en    = ~sync_q.out_enable_n;
	assign par_out     = store_q;
	assign par_out_oe  = {WIDTH{drive_en}};
	assign cascade_out = shift_q[WIDTH-1];
endmodule : slr_top
`default_nettype wire

// File: sim/slr_checker.sv
// checker: pin-to-output relations of slr_top
// bound into slr_top, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module slr_checker(input wire logic clk_sys,rst,shift_clock_in,store_clock_in,shift_clear_n,
	out_enable_n,cascade_out,input wire logic [7:0] par_out,par_out_oe);
default clocking @(posedge clk_sys); endclocking
default disable iff (rst);
property p_off; out_enable_n[*3] |-> par_out_oe==8'h00; endproperty
a_off: assert property (p_off) else $error("oe off");
property p_on; !out_enable_n[*4] |-> par_out_oe==8'hFF; endproperty
a_on: assert property (p_on) else $error("oe on");
property p_clr; !shift_clear_n[*4] |-> !cascade_out; endproperty
a_clr: assert property (p_clr) else $error("clear");
property p_st; !store_clock_in[*5] |-> $stable(par_out); endproperty
a_st: assert property (p_st) else $error("store");
property p_sh; (!shift_clock_in&&shift_clear_n)[*5] |-> $stable(cascade_out); endproperty
a_sh: assert property (p_sh) else $error("shift");
property p_keep; (!shift_clear_n&&!store_clock_in)[*5] |-> $stable(par_out); endproperty
a_keep: assert property (p_keep) else $error("clear touched storage");
endmodule : slr_checker
bind slr_top slr_checker i_chk(.*);
`default_nettype wire

// File: sim/slr_host.sv
// host model: drives serial data, clocks and clear
// assumes clk_sys; each pin held 3 clk_sys periods
`timescale 1ns/1ps
`default_nettype none
module slr_host(input wire logic clk_sys,output var logic bit_stream_in,shift_clock_in,
	store_clock_in,shift_clear_n);
initial {bit_stream_in,shift_clock_in,store_clock_in,shift_clear_n}=4'h1;
task automatic hold; repeat(3) @(posedge clk_sys); endtask : hold
task automatic send(input logic [7:0] v);
	for (int i=7;i>=0;i--) begin
		hold; bit_stream_in<=v[i]; hold; shift_clock_in<=1'h1; hold; shift_clock_in<=1'h0;
	end
	hold; store_clock_in<=1'h1; hold; store_clock_in<=1'h0;
endtask : send
task automatic tied(input logic b);
	hold; bit_stream_in<=b; hold; {shift_clock_in,store_clock_in}<=2'h3;
	hold; {shift_clock_in,store_clock_in}<=2'h0;
endtask : tied
task automatic clr; hold; shift_clear_n<=1'h0; hold; shift_clear_n<=1'h1; endtask : clr
endmodule : slr_host
`default_nettype wire

// File: sim/serial_to_parallel_latch_register_test.sv
// bench: loads bytes, checks outputs, enable and clear
// assumes slr_top with default width
`timescale 1ns/1ps
`default_nettype none
module serial_to_parallel_latch_register_test;
logic clk_sys=0,rst=1,out_enable_n=0;
wire logic bit_stream_in,shift_clock_in,store_clock_in,shift_clear_n,cascade_out;
wire logic [7:0] par_out,par_out_oe;
logic [7:0] rows[2]='{8'h3C,8'hA5};
int fails=0,compares=0;
slr_top i_dut(.*);
slr_host i_host(.*);
always #20 clk_sys=~clk_sys;
task automatic chk(input logic [7:0] g,e); compares++;
	if (g!==e) begin fails++; $display("[FAIL] %0t got %h exp %h",$time,g,e); end
endtask : chk
task automatic stop_test; $display("fails %0d compares %0d",fails,compares);
	if (fails==0&&compares>0) $display("Test passed"); else $display("Test failed");
	$finish; endtask : stop_test
initial begin #400us; fails++; stop_test; end
initial begin
	repeat(6) @(posedge clk_sys); rst<=0;
	foreach (rows[i]) begin
		i_host.send(rows[i]); repeat(4) @(posedge clk_sys);
		chk(par_out,rows[i]);
		chk(8'(cascade_out),8'(rows[i][7]));
		chk(par_out_oe,8'hFF);
	end
	out_enable_n<=1; repeat(4) @(posedge clk_sys);
	chk(par_out_oe,8'h00);
	chk(8'(cascade_out),8'h01);
	i_host.clr(); repeat(4) @(posedge clk_sys);
	chk(8'(cascade_out),8'h00);
	chk(par_out,8'hA5);
	i_host.tied(1'h1); repeat(4) @(posedge clk_sys);
	chk(par_out,8'h00);
	i_host.tied(1'h0); repeat(4) @(posedge clk_sys);
	chk(par_out,8'h01);
	rst<=1; repeat(2) @(posedge clk_sys);
	chk(par_out,8'h00);
	rst<=0; repeat(2) @(posedge clk_sys);
	stop_test;
end
endmodule : serial_to_parallel_latch_register_test
`default_nettype wire
